// ==== slfd_checker.sv ====
// Port assertions for the segment display frame driver
`timescale 1ns/1ps
module slfd_checker
  import slfd_pkg::*;
#(
  parameter int NSEG = 25,
  parameter int NCOM = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Panel side
  input wire logic supply_ready,
  input wire logic [NCOM-1:0] com_oe,
  input wire logic [NSEG-1:0] seg_oe,
  input wire logic buffer_on,
  input wire logic frame_irq
);
  logic ie_ff;
  logic en_ff;
  logic pwr_ff;
  wire logic acc = psel && penable;
  wire logic bad = (paddr[1:0] != 2'h0) || (paddr == 8'h1C) || (paddr > 8'h6C);
  wire logic idle = pwr_ff || !en_ff;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Shadow of the enable bits, so drive checks need no register reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_ff <= 1'b0;
      en_ff <= 1'b0;
      pwr_ff <= 1'b1;
    end else if (acc && pwrite && paddr == SLFD_CTRLA_OFS) begin
      ie_ff <= pwdata[SLFD_IE_BIT];
      en_ff <= pwdata[SLFD_EN_BIT];
    end else if (acc && pwrite && paddr == SLFD_PWR_OFS) begin
      pwr_ff <= pwdata[0];
    end
  end
  // Bus answers
  pready_high_a: assert property (pready) else $error("pready low");
  rdata_idle_a: assert property (!acc |-> prdata == 32'h0) else $error("prdata outside access");
  err_idle_a: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
  err_unmapped_a: assert property (acc && bad |-> pslverr) else $error("no error on bad address");
  err_mapped_a: assert property (acc && !bad |-> !pslverr) else $error("error on mapped address");
  // Drive inhibits
  supply_inhibit_a: assert property (!supply_ready |=> com_oe == '0 && seg_oe == '0)
    else $error("drive while supply low");
  idle_quiet_a: assert property (idle [*3] |-> com_oe == '0 && seg_oe == '0 && !buffer_on)
    else $error("drive while idle");
  irq_masked_a: assert property (!$past(ie_ff) |-> !frame_irq)
    else $error("irq while disabled");
  buffer_scope_a: assert property (buffer_on |-> com_oe[0])
    else $error("buffers on while pins tri-stated");
  // Main scenarios
  irq_seen_c: cover property ($rose(frame_irq));
  drive_stop_c: cover property ($fell(buffer_on));
  bus_error_c: cover property (acc && pslverr);
endmodule // slfd_checker

// ==== slfd_panel_model.sv ====
// Passive panel model: full-swing cells, DC sum and drive timing
`timescale 1ns/1ps
module slfd_panel_model (
  // Clock and control
  input wire logic pclk,
  input wire logic clr,
  // Drive from the block
  input wire logic [7:0] com_level,
  input wire logic [3:0] com_oe,
  input wire logic [49:0] seg_level,
  input wire logic [24:0] seg_oe,
  // Observations
  output logic [24:0] lit [4],
  output int dc_acc,
  output int step_len,
  output int drive_len
);
  int scnt = 0;
  int dcnt = 0;
  logic [7:0] last_com = 8'h00;
  // A cell turns on only with full swing across it; tri-stated pins do not count
  always @(posedge pclk) begin
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 25; s++) begin
        if (clr) begin
          lit[c][s] <= 1'b0;
        end else if (com_oe[c] && seg_oe[s] && com_level[2*c+:2] inside {2'h0, 2'h3} &&
            (com_level[2*c+:2] ^ seg_level[2*s+:2]) == 2'h3) begin
          lit[c][s] <= 1'b1;
        end
      end
    end
    if (clr) begin
      dc_acc <= 0;
    end else if (com_oe[0] && seg_oe[0]) begin
      dc_acc <= dc_acc + int'(seg_level[1:0]) - int'(com_level[1:0]);
    end
    last_com <= com_level;
    scnt <= (com_level != last_com) ? 1 : scnt + 1;
    if (com_level != last_com) begin
      step_len <= scnt;
    end
    dcnt <= (com_oe != 4'h0) ? dcnt + 1 : 0;
    if (com_oe == 4'h0 && dcnt != 0) begin
      drive_len <= dcnt;
    end
  end
endmodule // slfd_panel_model

// ==== slfd_pkg.sv ====
// Constants, register map and level codes of the segment display frame driver
// How it works
// R1: Drives up to four common lines and twenty-five segment lines.
// R2: Duty is static, one half, one third or one quarter.
// R3: Bias is static, one half or one third.
// R4: Source clock is the system clock unless the async select picks the pin.
// R5: Twelve-bit ripple counter divides source by 16 up to 4096.
// R6: A further divide by 1 to 8 gives the frame timing tick.
// R7: One memory group per common; a one bit lights the segment.
// R8: Lit segments run opposite to the addressed common, dark ones in phase.
// R9: Every frame starts on common zero at full swing.
// R10: Common n takes memory words 5n to 5n+3 into the decoder, word 5n+3 for bit 0 only.
// R11: Commons follow in turn up to the duty count, then a new frame.
// R12: Memory is snapshotted before each frame; writes never disturb it.
// R13: Extra intermediate levels: one for half bias, two for third bias.
// R14: Drive polarity alternates so no segment sees a DC component.
// R15: All outputs stay inhibited until the supply ready signal rises.
// R16: Buffers run for the drive time only, then pins are tri-stated.
// R17: Software clears power reduce before use; block idles while it is set.
// R18: Two-common duty accepts third bias as well as half bias.
// R19: Unused segment and common pins are released as port pins.
// R20: Memory, blanking, low power select and contrast are latched together.
// R21: Low power waveform latches and flags only every second frame.
// R22: Blanking finishes the frame, then grounds all pins, memory kept.
// R23: Frame flag sets at each latch; interrupt when enabled.
// R24: Sequencer runs only while enabled and restarts at common zero.
package slfd_pkg;
  // Register byte offsets
  localparam logic [7:0] SLFD_CTRLA_OFS = 8'h00;
  localparam logic [7:0] SLFD_CTRLB_OFS = 8'h04;
  localparam logic [7:0] SLFD_FRR_OFS = 8'h08;
  localparam logic [7:0] SLFD_CCR_OFS = 8'h0C;
  localparam logic [7:0] SLFD_PWR_OFS = 8'h10;
  localparam logic [7:0] SLFD_MASK_OFS = 8'h14;
  localparam logic [7:0] SLFD_STAT_OFS = 8'h18;
  localparam logic [7:0] SLFD_MEM_OFS = 8'h20;
  localparam int SLFD_MEM_WORDS = 20;
  localparam int SLFD_GRP_BITS = 40;
  // Field positions
  localparam int SLFD_EN_BIT = 7;
  localparam int SLFD_LPW_BIT = 6;
  localparam int SLFD_FLAG_BIT = 4;
  localparam int SLFD_IE_BIT = 3;
  localparam int SLFD_BLANK_BIT = 0;
  localparam int SLFD_ACS_BIT = 7;
  localparam int SLFD_DUTY_LSB = 4;
  localparam int SLFD_BIAS_LSB = 0;
  localparam int SLFD_PS_LSB = 4;
  localparam int SLFD_CD_LSB = 0;
  localparam int SLFD_DT_LSB = 5;
  localparam int SLFD_CC_LSB = 0;
  // Reset values
  localparam logic [7:0] SLFD_CTRL_RST = 8'h00;
  localparam logic SLFD_PWR_RST = 1'b1;
  localparam logic [24:0] SLFD_MASK_RST = 25'h1FFFFFF;
  // Bias codes and drive level codes
  localparam logic [1:0] SLFD_BIAS_STATIC = 2'h0;
  localparam logic [1:0] SLFD_BIAS_HALF = 2'h1;
  localparam logic [1:0] SLFD_LVL_GND = 2'h0;
  localparam logic [1:0] SLFD_LVL_LOW = 2'h1;
  localparam logic [1:0] SLFD_LVL_HIGH = 2'h2;
  localparam logic [1:0] SLFD_LVL_FULL = 2'h3;
  localparam logic [2:0] SLFD_DT_ALWAYS = 3'h7;
  // Sequencer states
  typedef enum logic [2:0] {
    SLFD_ST_OFF = 3'b001,
    SLFD_ST_RUN = 3'b010,
    SLFD_ST_BLANK = 3'b100
  } slfd_state_t;
endpackage

// ==== slfd_top.sv ====
// Segment display frame driver: APB registers, prescaler, sequencer, level decoder
`timescale 1ns/1ps
module slfd_top
  import slfd_pkg::*;
#(
  parameter int NSEG = 25,
  parameter int NCOM = 4,
  parameter int DRIVE_STEP_CYC = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock pin and supply status
  input wire logic timer_osc_input_pin,
  input wire logic supply_ready,
  // Panel drive
  output logic [2*NCOM-1:0] com_level,
  output logic [NCOM-1:0] com_oe,
  output logic [2*NSEG-1:0] seg_level,
  output logic [NSEG-1:0] seg_oe,
  output logic buffer_on,
  output logic [NCOM-1:0] com_port_release,
  output logic [NSEG-1:0] seg_port_release,
  output logic [3:0] contrast_level,
  output logic frame_irq
);

  // Registers written by software
  logic [7:0] ctrla_ff;
  logic [7:0] ctrlb_ff;
  logic [7:0] frr_ff;
  logic [7:0] ccr_ff;
  logic pwr_ff;
  logic [24:0] mask_ff;
  logic [7:0] mem_ff [SLFD_MEM_WORDS];
  logic flag_ff;
  // Frame snapshot
  logic [8*SLFD_MEM_WORDS-1:0] lat_ff;
  logic lat_blank_ff;
  logic lat_lpw_ff;
  logic [3:0] lat_cc_ff;
  // Timing and sequencing
  logic osc_prev_ff;
  logic [11:0] ripple_ff;
  logic [2:0] div_ff;
  logic [1:0] com_idx_ff;
  logic half_ff;
  logic par_ff;
  logic [15:0] drive_cnt_ff;
  slfd_state_t state_ff;
  slfd_state_t nxt_state;
  // APB answer flops
  logic [31:0] rdata_ff;
  logic err_ff;

  // Prescale tap mask: division by 16 .. 4096
  function automatic logic [11:0] presc_mask(input logic [2:0] sel);
    logic [11:0] m;
    m = 12'h000;
    case (sel)
      3'h0: m = 12'h00F;
      3'h1: m = 12'h03F;
      3'h2: m = 12'h07F;
      3'h3: m = 12'h0FF;
      3'h4: m = 12'h1FF;
      3'h5: m = 12'h3FF;
      3'h6: m = 12'h7FF;
      default: m = 12'hFFF;
    endcase
    return m;
  endfunction

  // Drive level of one pin for the current common slot and polarity
  function automatic logic [1:0] pin_level(input logic [1:0] bias, input logic is_com,
                                           input logic sel, input logic pol);
    logic [1:0] l;
    l = SLFD_LVL_GND;
    if (is_com) begin
      if (sel) begin
        l = pol ? SLFD_LVL_FULL : SLFD_LVL_GND; // [R9]
      end else if (bias == SLFD_BIAS_HALF) begin
        l = SLFD_LVL_LOW; // [R13]
      end else if (bias != SLFD_BIAS_STATIC) begin
        l = pol ? SLFD_LVL_LOW : SLFD_LVL_HIGH; // [R13] [R18]
      end else begin
        l = SLFD_LVL_GND;
      end
    end else begin
      if (sel) begin
        l = pol ? SLFD_LVL_GND : SLFD_LVL_FULL; // [R8]
      end else if (bias != SLFD_BIAS_STATIC && bias != SLFD_BIAS_HALF) begin
        l = pol ? SLFD_LVL_HIGH : SLFD_LVL_LOW; // [R13]
      end else begin
        l = pol ? SLFD_LVL_FULL : SLFD_LVL_GND; // [R8]
      end
    end
    return l;
  endfunction

  // Field decode
  wire logic enable = ctrla_ff[SLFD_EN_BIT];
  wire logic irq_en = ctrla_ff[SLFD_IE_BIT];
  wire logic async_clock_select = ctrlb_ff[SLFD_ACS_BIT];
  wire logic [1:0] duty_sel = ctrlb_ff[SLFD_DUTY_LSB +: 2];
  wire logic [1:0] bias_sel = ctrlb_ff[SLFD_BIAS_LSB +: 2]; // [R3]
  wire logic [2:0] frame_prescale_select = frr_ff[SLFD_PS_LSB +: 3];
  wire logic [2:0] frame_clock_divide = frr_ff[SLFD_CD_LSB +: 3];
  wire logic [2:0] drive_time_select = ccr_ff[SLFD_DT_LSB +: 3];
  wire logic active = enable & ~pwr_ff; // [R17] [R24]

  // APB decode
  wire logic acc = psel & penable;
  wire logic setup = psel & ~penable;
  wire logic mem_hit = paddr[7:2] >= SLFD_MEM_OFS[7:2] &&
                       paddr[7:2] < SLFD_MEM_OFS[7:2] + 6'(SLFD_MEM_WORDS);
  wire logic [4:0] mem_idx = 5'(paddr[7:2] - SLFD_MEM_OFS[7:2]);
  wire logic reg_hit = paddr[1:0] == 2'h0 && (mem_hit || paddr <= SLFD_STAT_OFS);
  wire logic wr = acc & pwrite & reg_hit;
  wire logic wr_a = wr && paddr == SLFD_CTRLA_OFS;

  // Source clock, prescaler and divider
  wire logic src_tick = async_clock_select ? (timer_osc_input_pin & ~osc_prev_ff) : 1'b1; // [R4]
  wire logic [11:0] pmask = presc_mask(frame_prescale_select);
  wire logic ps_tick = active & src_tick & ((ripple_ff & pmask) == pmask); // [R5]
  wire logic step = ps_tick && div_ff == frame_clock_divide; // [R6]

  // Frame position
  wire logic slot_end = lat_lpw_ff | half_ff;
  wire logic last_com = com_idx_ff == duty_sel; // [R2] [R11]
  wire logic frame_end = step & slot_end & last_com;
  wire logic start = active && state_ff == SLFD_ST_OFF;
  wire logic latch_now = start | (frame_end & (~lat_lpw_ff | par_ff)); // [R12] [R21]
  wire logic pol = lat_lpw_ff ? par_ff : half_ff; // [R14]
  wire logic drive_live = drive_cnt_ff != 16'h0000 || drive_time_select == SLFD_DT_ALWAYS;
  wire logic blanked = state_ff == SLFD_ST_BLANK && lat_blank_ff; // [R20] [R22]
  wire logic pins_on = active & supply_ready & (blanked | drive_live); // [R15] [R16]

  // Sequencer state selection
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SLFD_ST_OFF: begin
        if (active) begin
          nxt_state = SLFD_ST_RUN;
        end
      end
      SLFD_ST_RUN: begin
        if (!active) begin
          nxt_state = SLFD_ST_OFF;
        end else if (latch_now && ctrla_ff[SLFD_BLANK_BIT]) begin
          nxt_state = SLFD_ST_BLANK; // [R22]
        end
      end
      SLFD_ST_BLANK: begin
        if (!active) begin
          nxt_state = SLFD_ST_OFF;
        end else if (latch_now && !ctrla_ff[SLFD_BLANK_BIT]) begin
          nxt_state = SLFD_ST_RUN;
        end
      end
      default: nxt_state = SLFD_ST_OFF;
    endcase
  end

  // Control registers; the flag set beats a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrla_ff <= SLFD_CTRL_RST;
      ctrlb_ff <= SLFD_CTRL_RST;
      frr_ff <= SLFD_CTRL_RST;
      ccr_ff <= SLFD_CTRL_RST;
      pwr_ff <= SLFD_PWR_RST;
      mask_ff <= SLFD_MASK_RST;
    end else if (wr) begin
      if (wr_a) ctrla_ff <= pwdata[7:0];
      if (paddr == SLFD_CTRLB_OFS) ctrlb_ff <= pwdata[7:0];
      if (paddr == SLFD_FRR_OFS) frr_ff <= pwdata[7:0];
      if (paddr == SLFD_CCR_OFS) ccr_ff <= pwdata[7:0];
      if (paddr == SLFD_PWR_OFS) pwr_ff <= pwdata[0];
      if (paddr == SLFD_MASK_OFS) mask_ff <= pwdata[24:0];
    end
  end

  // Frame event flag, write one to clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= 1'b0;
    end else if (latch_now) begin
      flag_ff <= 1'b1; // [R23]
    end else if (wr_a && pwdata[SLFD_FLAG_BIT]) begin
      flag_ff <= 1'b0;
    end
  end

  // Display memory, one group of five words per common
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SLFD_MEM_WORDS; i++) mem_ff[i] <= 8'h00;
    end else if (wr && mem_hit) begin
      mem_ff[mem_idx] <= pwdata[7:0]; // [R7]
    end
  end

  // Snapshot of memory and frame settings at frame start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_ff <= '0;
      lat_blank_ff <= 1'b0;
      lat_lpw_ff <= 1'b0;
      lat_cc_ff <= 4'h0;
    end else if (latch_now) begin
      for (int i = 0; i < SLFD_MEM_WORDS; i++) lat_ff[8*i +: 8] <= mem_ff[i]; // [R12]
      lat_blank_ff <= ctrla_ff[SLFD_BLANK_BIT]; // [R20]
      lat_lpw_ff <= ctrla_ff[SLFD_LPW_BIT]; // [R20]
      lat_cc_ff <= ccr_ff[SLFD_CC_LSB +: 4]; // [R20]
    end
  end

  // Ripple prescaler and 1-to-8 divider; both held clear while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev_ff <= 1'b0;
      ripple_ff <= 12'h000;
      div_ff <= 3'h0;
    end else begin
      osc_prev_ff <= timer_osc_input_pin;
      if (!active) begin
        ripple_ff <= 12'h000; // [R24]
        div_ff <= 3'h0;
      end else if (src_tick) begin
        ripple_ff <= ripple_ff + 12'h001; // [R5]
        if (ps_tick) div_ff <= step ? 3'h0 : div_ff + 3'h1; // [R6]
      end
    end
  end

  // Common slot walk: two half slots each, or one in low power mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SLFD_ST_OFF;
      com_idx_ff <= 2'h0;
      half_ff <= 1'b0;
      par_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (!active) begin
        com_idx_ff <= 2'h0; // [R24]
        half_ff <= 1'b0;
        par_ff <= 1'b0;
      end else if (step) begin
        half_ff <= lat_lpw_ff ? 1'b0 : ~half_ff; // [R14]
        if (frame_end) begin
          com_idx_ff <= 2'h0; // [R9] [R11]
          par_ff <= ~par_ff; // [R21]
        end else if (slot_end) begin
          com_idx_ff <= com_idx_ff + 2'h1; // [R11]
        end
      end
    end
  end

  // Drive-time counter restarts at each level change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_cnt_ff <= 16'h0000;
    end else if (step || start) begin
      drive_cnt_ff <= 16'((int'(drive_time_select) + 1) * DRIVE_STEP_CYC); // [R16]
    end else if (drive_cnt_ff != 16'h0000) begin
      drive_cnt_ff <= drive_cnt_ff - 16'h0001;
    end
  end

  // Level registers per common and segment; blanking grounds every pin
  genvar g;
  generate
    for (g = 0; g < NCOM; g++) begin : g_com
      wire logic used = duty_sel >= 2'(g); // [R1]
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          com_level[2*g +: 2] <= SLFD_LVL_GND;
          com_oe[g] <= 1'b0;
          com_port_release[g] <= 1'b1;
        end else begin
          com_level[2*g +: 2] <= (blanked || !active) ? SLFD_LVL_GND :
            pin_level(bias_sel, 1'b1, com_idx_ff == 2'(g), pol); // [R22]
          com_oe[g] <= pins_on & used; // [R15] [R16]
          com_port_release[g] <= ~(active & used); // [R19]
        end
      end
    end
    for (g = 0; g < NSEG; g++) begin : g_seg
      wire logic lit = lat_ff[int'(com_idx_ff) * SLFD_GRP_BITS + g]; // [R10]
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          seg_level[2*g +: 2] <= SLFD_LVL_GND;
          seg_oe[g] <= 1'b0;
          seg_port_release[g] <= 1'b1;
        end else begin
          seg_level[2*g +: 2] <= (blanked || !active) ? SLFD_LVL_GND :
            pin_level(bias_sel, 1'b0, lit, pol); // [R8] [R22]
          seg_oe[g] <= pins_on & mask_ff[g]; // [R16]
          seg_port_release[g] <= ~(active & mask_ff[g]); // [R19]
        end
      end
    end
  endgenerate

  // Buffer enable, contrast and interrupt; buffers only matter with bias levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_on <= 1'b0;
      contrast_level <= 4'h0;
      frame_irq <= 1'b0;
    end else begin
      buffer_on <= pins_on & ~blanked & drive_live & (bias_sel != SLFD_BIAS_STATIC); // [R13] [R16]
      contrast_level <= lat_cc_ff;
      frame_irq <= flag_ff & irq_en; // [R23]
    end
  end

  // Read mux, captured in the setup cycle so the access phase has no wait
  wire logic [31:0] status = {27'h0, active, supply_ready, blanked, com_idx_ff};
  wire logic [7:0] ctrla_rd = {ctrla_ff[7:5], flag_ff, ctrla_ff[3:0]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h0;
      err_ff <= 1'b0;
    end else if (setup) begin
      err_ff <= ~reg_hit;
      rdata_ff <= 32'h0;
      if (mem_hit) rdata_ff <= {24'h0, mem_ff[mem_idx]};
      else if (paddr == SLFD_CTRLA_OFS) rdata_ff <= {24'h0, ctrla_rd};
      else if (paddr == SLFD_CTRLB_OFS) rdata_ff <= {24'h0, ctrlb_ff};
      else if (paddr == SLFD_FRR_OFS) rdata_ff <= {24'h0, frr_ff};
      else if (paddr == SLFD_CCR_OFS) rdata_ff <= {24'h0, ccr_ff};
      else if (paddr == SLFD_PWR_OFS) rdata_ff <= {31'h0, pwr_ff};
      else if (paddr == SLFD_MASK_OFS) rdata_ff <= {7'h0, mask_ff};
      else if (paddr == SLFD_STAT_OFS) rdata_ff <= status;
    end
  end

  // APB answers
  assign pready = 1'b1;
  assign pslverr = acc & err_ff;
  assign prdata = (acc & ~pwrite & ~err_ff) ? rdata_ff : 32'h0;

endmodule // slfd_top

// ==== slfd_top_tb.sv ====
// Self-checking testbench for the segment display frame driver
`timescale 1ns/1ps
module slfd_top_tb;
  import slfd_pkg::*;
  localparam int DRIVE_STEP_LEN = 16;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic timer_osc_input_pin = 1'b0;
  logic supply_ready = 1'b1;
  logic clr = 1'b0;
  logic osc_run = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] com_level;
  logic [3:0] com_oe;
  logic [49:0] seg_level;
  logic [24:0] seg_oe;
  logic buffer_on;
  logic [3:0] com_port_release;
  logic [24:0] seg_port_release;
  logic [3:0] contrast_level;
  logic frame_irq;
  logic [24:0] lit [4];
  int dc_acc;
  int step_len;
  int drive_len;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 32'hBDEC29BF;
  int mem_m [20];
  int duty_t [5] = '{0, 1, 1, 2, 3};
  int bias_t [5] = '{0, 1, 2, 2, 3};
  logic [31:0] rd_d;
  logic rd_e;
  int dv;
  int fac;
  logic [24:0] msk;
  slfd_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .timer_osc_input_pin, .supply_ready, .com_level, .com_oe, .seg_level, .seg_oe, .buffer_on,
    .com_port_release, .seg_port_release, .contrast_level, .frame_irq);
  slfd_panel_model panel (.pclk, .clr, .com_level, .com_oe, .seg_level, .seg_oe, .lit, .dc_acc,
    .step_len, .drive_len);
  // 200 MHz clock, pin clock toggles every cycle once started
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) if (osc_run) timer_osc_input_pin <= !timer_osc_input_pin;
  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd_d, rd_e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, rd_d, rd_e);
    chk("prdata", x, rd_d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic restart();
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
  endtask
  task automatic wait_irq();
    int t;
    t = 0;
    while (frame_irq !== 1'b1 && t < 2000) begin
      @(posedge pclk);
      t++;
    end
    chk("frame_irq", 1, frame_irq);
  endtask
  // Expected lit cells of one common: bit s of the five-word group
  function automatic logic [24:0] exp_lit(input int c);
    logic [24:0] v;
    for (int s = 0; s < 25; s++) v[s] = mem_m[5*c + s/8][s%8];
    return v;
  endfunction
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("com release", 4'hF, com_port_release);
    rdc(SLFD_CTRLA_OFS, 32'h0);
    rdc(SLFD_CTRLB_OFS, 32'h0);
    rdc(SLFD_PWR_OFS, 32'h1);
    rdc(SLFD_MASK_OFS, 32'h01FFFFFF);
    apb(1'b0, 8'h1C, 32'h0, rd_d, rd_e);
    chk("pslverr", 1, rd_e);
    for (int w = 0; w < 20; w++) begin
      mem_m[w] = $random(seed) & 8'hFF;
      wr(8'(SLFD_MEM_OFS + w * 4), 32'(mem_m[w]));
    end
    for (int w = 0; w < 20; w++) rdc(8'(SLFD_MEM_OFS + w * 4), 32'(mem_m[w]));
    wr(SLFD_CCR_OFS, 32'hE5);
    wr(SLFD_FRR_OFS, 32'h0);
    wr(SLFD_PWR_OFS, 32'h0);
    // Every duty and bias, default and low power wave
    for (int lp = 0; lp < 2; lp++) begin
      for (int k = 0; k < 5; k++) begin
        wr(SLFD_CTRLA_OFS, 32'h0);
        wr(SLFD_CTRLB_OFS, 32'(duty_t[k] * 16 + bias_t[k]));
        wr(SLFD_CTRLA_OFS, 32'(8'h88 + lp * 64));
        apb(1'b0, SLFD_STAT_OFS, 32'h0, rd_d, rd_e);
        chk("current common", 0, rd_d[1:0]);
        restart();
        cyc(600);
        for (int c = 0; c < 4; c++) chk("lit", (c <= duty_t[k]) ? exp_lit(c) : 0, lit[c]);
        chk("dc balance", 1, dc_acc <= 200 && dc_acc >= -200);
        chk("com release", 4'(4'hF << (duty_t[k] + 1)), com_port_release);
        chk("frame_irq", 1, frame_irq);
      end
    end
    // Contrast written mid-frame waits for the next latch
    wr(SLFD_CTRLA_OFS, 32'hD8);
    cyc(2); // Registered irq needs a cycle to show the clear, else the wait ends at once
    wait_irq();
    wr(SLFD_CCR_OFS, 32'hEA);
    wr(SLFD_CTRLA_OFS, 32'hD8);
    cyc(2);
    chk("contrast", 4'h5, contrast_level);
    chk("frame_irq", 0, frame_irq);
    wait_irq();
    cyc(2);
    chk("contrast", 4'hA, contrast_level);
    // Blanking grounds every pin and keeps memory
    wr(SLFD_CTRLA_OFS, 32'h89);
    cyc(400);
    chk("com level", 0, com_level);
    chk("seg level", 0, seg_level);
    rdc(SLFD_MEM_OFS, 32'(mem_m[0]));
    wr(SLFD_CTRLA_OFS, 32'h88);
    // Drive time against a 64-cycle step
    wr(SLFD_FRR_OFS, 32'h3);
    for (int d = 0; d < 3; d += 2) begin
      wr(SLFD_CCR_OFS, 32'(d * 32 + 10));
      cyc(1200);
      chk("drive length", (d + 1) * DRIVE_STEP_LEN, drive_len);
    end
    wr(SLFD_CCR_OFS, 32'hEA);
    for (int ps = 0; ps < 3; ps++) begin
      dv = $random(seed) & 7;
      fac = (ps == 0) ? 16 : 32 << ps;
      wr(SLFD_FRR_OFS, 32'(ps * 16 + dv));
      cyc(fac * (dv + 1) * 3 + fac * 8 + 600); // Divider may wrap once after a smaller divide is written
      chk("step length", fac * (dv + 1), step_len);
    end
    wr(SLFD_FRR_OFS, 32'h0);
    supply_ready <= 1'b0;
    cyc(3);
    chk("oe", 0, {com_oe, seg_oe});
    supply_ready <= 1'b1;
    msk = 25'($random(seed));
    wr(SLFD_MASK_OFS, 32'(msk));
    cyc(300);
    chk("seg release", 25'(~msk), seg_port_release);
    // Pin clock: no frames while it stands, frames once it runs
    wr(SLFD_CTRLB_OFS, 32'hB3);
    wr(SLFD_CTRLA_OFS, 32'h98);
    cyc(300);
    chk("frame_irq", 0, frame_irq);
    osc_run <= 1'b1;
    wait_irq();
    end_sim();
  end
endmodule // slfd_top_tb
bind slfd_top slfd_checker #(.NSEG(NSEG), .NCOM(NCOM)) chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .supply_ready, .com_oe, .seg_oe, .buffer_on, .frame_irq);
